// File: fgq_host.sv
`default_nettype none
// Notes on behaviour
// [RULE_01] Write-protect low blocks program/erase of boundary sectors.
// [RULE_02] Write-protect high leaves boundary sectors to prior protection.
// [RULE_03] Write-protect input is pulled up; released pin means unprotected.
// [RULE_04] Program only starts after the unlock cycles precede it.
// [RULE_05] Under supply lockout no writes; device returns to array read.
// [RULE_06] Control pulses under 3 ns never start a write cycle.
// [RULE_07] Writes inhibited if output enable low or chip/write enable high.
// [RULE_08] Host writes with chip and write enable low, output enable high.
// [RULE_09] Write enable held low through power-up gives no command.
// [RULE_10] Power-up puts the command state machine in array read.
// [RULE_11] Data 98h to address 55h enters query mode from array read.
// [RULE_12] Query mode lasts until the reset command returns array read.
// [RULE_13] Query command is accepted from autoselect mode too.
// [RULE_14] Words 10h-12h read 0051h, 0052h, 0059h; byte address doubles.
// [RULE_15] Words 13h-16h read 0002h, 0000h, 0040h, 0000h.
// [RULE_16] Words 17h to 1Ah read 0000h.
// [RULE_17] Words 1Bh, 1Ch read supply codes 0027h and 0036h.
// [RULE_18] Words 1Dh, 1Eh read 0000h.
// [RULE_19] Word 1Fh reads 0007h.
// [RULE_20] Words 20h, 21h read 0007h and 000Ah.
// [RULE_21] Word 22h reads 0000h.
// [RULE_22] Words 23h to 26h read 0003h, 0005h, 0004h, 0000h.
// [RULE_23] In query mode no write other than reset starts program or erase.
module fgq_host #(
  parameter int ADDR_W   = fgq_pkg::ADDR_W,
  parameter int SECTOR_W = 15
)(
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire logic [2:0]                 cmd_op,
  input  wire logic [ADDR_W-1:0]          cmd_addr,
  input  wire logic [fgq_pkg::DATA_W-1:0] cmd_data,
  input  wire logic                       byte_mode,
  input  wire logic                       wp_enable,
  output logic                            rsp_valid,
  output logic [fgq_pkg::DATA_W-1:0]      rsp_data,
  output logic                            rsp_match,
  output logic                            rsp_error,
  output logic                            query_mode,
  output logic                            lockout,
  output logic [ADDR_W-1:0]               flash_addr,
  output logic [fgq_pkg::DATA_W-1:0]      flash_dq_o,
  output logic                            flash_dq_oe_b,
  input  wire logic [fgq_pkg::DATA_W-1:0] flash_dq_i,
  output logic                            flash_ce_b,
  output logic                            flash_oe_b,
  output logic                            flash_we_b,
  output logic                            flash_wp_o,
  output logic                            flash_wp_oe_b,
  input  wire logic                       flash_lockout
);

  localparam int CW = fgq_pkg::CNT_W;

  if (SECTOR_W >= ADDR_W || SECTOR_W < 1) begin : g_bad_sector
    $error("fgq_host: SECTOR_W must lie between 1 and ADDR_W-1");
  end
  if (fgq_pkg::POWERUP_CYC >= (1 << CW) ||
      fgq_pkg::READ_CYC >= (1 << CW)) begin : g_bad_count
    $error("fgq_host: timing count exceeds counter width");
  end
  if (fgq_pkg::WE_LOW_CYC <= fgq_pkg::GLITCH_CYC) begin : g_bad_pulse
    $error("fgq_host: write pulse not longer than glitch filter");
  end

  typedef enum logic [2:0] {
    ST_POWER   = 3'h0,
    ST_IDLE    = 3'h1,
    ST_WR_SET  = 3'h2,
    ST_WR_LOW  = 3'h3,
    ST_WR_HIGH = 3'h4,
    ST_RD      = 3'h5,
    ST_DONE    = 3'h6
  } fgq_state_e;

  fgq_state_e                 state;
  fgq_state_e                 next_state;
  logic [CW-1:0]              cnt;
  logic [CW-1:0]              next_cnt;
  logic [1:0]                 step;
  logic [2:0]                 op;
  logic [ADDR_W-1:0]          op_addr;
  logic [fgq_pkg::DATA_W-1:0] op_data;
  logic                       op_err;
  logic [fgq_pkg::DATA_W-1:0] dq_sync;
  logic                       lockout_sync;

  fgq_sync #(
    .W (fgq_pkg::DATA_W + 1)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({flash_lockout, flash_dq_i}),
    .q     ({lockout_sync, dq_sync})
  );

  wire accept     = cmd_valid && cmd_ready;
  wire is_program = (cmd_op == fgq_pkg::OP_PROGRAM);
  wire is_write   = (cmd_op == fgq_pkg::OP_WRITE) || is_program ||
                    (cmd_op == fgq_pkg::OP_QUERY_ENTER) ||
                    (cmd_op == fgq_pkg::OP_RESET);
  wire is_read    = (cmd_op == fgq_pkg::OP_READ) ||
                    (cmd_op == fgq_pkg::OP_QUERY_READ);
  wire [ADDR_W-SECTOR_W-1:0] sector = cmd_addr[ADDR_W-1:SECTOR_W];
  wire boundary   = (sector == '0) || (sector == '1);
  // Programs to boundary sectors are refused while the pin is pulled low.
  wire wp_block   = is_program && wp_enable && boundary; // [RULE_01]
  // Writes accepted under lockout and programs in query mode are never issued.
  wire lock_block = is_write && lockout_sync; // [RULE_05]
  wire qry_block  = (is_program || cmd_op == fgq_pkg::OP_WRITE) &&
                    query_mode; // [RULE_23]
  wire qread_bad  = (cmd_op == fgq_pkg::OP_QUERY_READ) && !query_mode;
  wire bad_op     = !is_write && !is_read;
  wire refuse     = wp_block || lock_block || qry_block || qread_bad ||
                    bad_op;

  // Program is the three unlock cycles followed by the data cycle.
  wire [1:0] last_step = (op==fgq_pkg::OP_PROGRAM) ? 2'h3 : 2'h0; // [RULE_04]
  wire [ADDR_W-1:0] unlock1_a = ADDR_W'(fgq_pkg::UNLOCK1_ADDR);
  wire [ADDR_W-1:0] unlock2_a = ADDR_W'(fgq_pkg::UNLOCK2_ADDR);
  // Query entry address doubles in byte mode, as do table reads.
  wire [ADDR_W-1:0] query_a   = byte_mode ?
                    ADDR_W'({fgq_pkg::QUERY_ADDR, 1'b0}) :
                    ADDR_W'(fgq_pkg::QUERY_ADDR); // [RULE_11]
  wire [ADDR_W-1:0] qread_a   = byte_mode ?
                    {op_addr[ADDR_W-2:0], 1'b0} : op_addr; // [RULE_14]

  logic [ADDR_W-1:0]          seq_addr;
  logic [fgq_pkg::DATA_W-1:0] seq_data;

  always_comb begin
    seq_addr = op_addr;
    seq_data = op_data;
    case (op)
      fgq_pkg::OP_PROGRAM: begin
        case (step)
          2'h0: begin
            seq_addr = unlock1_a;
            seq_data = 16'(fgq_pkg::UNLOCK1_DATA);
          end
          2'h1: begin
            seq_addr = unlock2_a;
            seq_data = 16'(fgq_pkg::UNLOCK2_DATA);
          end
          2'h2: begin
            seq_addr = unlock1_a;
            seq_data = 16'(fgq_pkg::CMD_PROGRAM);
          end
          default: begin
            seq_addr = op_addr;
            seq_data = op_data;
          end
        endcase
      end
      fgq_pkg::OP_QUERY_ENTER: begin
        seq_addr = query_a;
        seq_data = 16'(fgq_pkg::CMD_QUERY); // [RULE_11] [RULE_13]
      end
      fgq_pkg::OP_RESET: begin
        seq_data = 16'(fgq_pkg::CMD_RESET); // [RULE_12]
      end
      fgq_pkg::OP_QUERY_READ: begin
        seq_addr = qread_a;
      end
      default: begin
        seq_addr = op_addr;
        seq_data = op_data;
      end
    endcase
  end

  wire cnt_zero = (cnt == '0);

  always_comb begin
    next_state = state;
    next_cnt   = cnt_zero ? cnt : cnt - 1'b1;
    case (state)
      ST_POWER: begin
        // Pins other than write protect stay inactive until the device has finished powering up.
        if (cnt_zero) begin // [RULE_09] [RULE_10]
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (accept) begin
          if (refuse) begin
            next_state = ST_DONE;
          end else if (is_read) begin
            next_state = ST_RD;
            next_cnt   = CW'(fgq_pkg::READ_CYC - 1);
          end else begin
            next_state = ST_WR_SET;
          end
        end
      end
      ST_WR_SET: begin
        next_state = ST_WR_LOW;
        next_cnt   = CW'(fgq_pkg::WE_LOW_CYC - 1);
      end
      ST_WR_LOW: begin
        // Write pulse is held well beyond the glitch filter width.
        if (cnt_zero) begin // [RULE_06]
          next_state = ST_WR_HIGH;
          next_cnt   = CW'(fgq_pkg::WE_HIGH_CYC - 1);
        end
      end
      ST_WR_HIGH: begin
        if (cnt_zero) begin
          next_state = (step == last_step) ? ST_DONE : ST_WR_SET;
        end
      end
      ST_RD: begin
        if (cnt_zero) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Chip enable is low through setup and the write pulse, output enable stays
  // high, and write enable is low only inside it.
  wire wr_active  = (next_state == ST_WR_SET) ||
                    (next_state == ST_WR_LOW); // [RULE_08]
  wire next_we_b  = (next_state != ST_WR_LOW); // [RULE_07]
  wire next_ce_b  = !(wr_active || next_state == ST_RD);
  wire next_oe_b  = (next_state != ST_RD); // [RULE_07]
  wire next_drive = wr_active || (next_state == ST_WR_HIGH);
  wire rd_end     = (state == ST_RD) && cnt_zero;
  wire wr_end     = (state == ST_WR_HIGH) && cnt_zero;
  wire low_byte_ok = dq_sync[7:0] == // [RULE_14] [RULE_15] [RULE_16] [RULE_17]
                     8'(fgq_pkg::query_expect(op_addr[7:0])); // [RULE_18]
  wire word_ok    = dq_sync == fgq_pkg::query_expect(op_addr[7:0]);
  // Table reads are checked against the fixed query contents.
  wire table_ok   = fgq_pkg::query_in_table(op_addr[7:0]) && // [RULE_19]
                    (byte_mode ? low_byte_ok : word_ok); // [RULE_20] [RULE_21]

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_POWER;
      cnt   <= CW'(fgq_pkg::POWERUP_CYC - 1);
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op      <= 3'h0;
      op_addr <= '0;
      op_data <= '0;
      op_err  <= 1'b0;
    end else if (accept) begin
      op      <= cmd_op;
      op_addr <= cmd_addr;
      op_data <= cmd_data;
      op_err  <= refuse;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      step <= 2'h0;
    end else if (accept) begin
      step <= 2'h0;
    end else if (wr_end && step != last_step) begin
      step <= step + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_ce_b    <= 1'b1;
      flash_oe_b    <= 1'b1;
      flash_we_b    <= 1'b1;
      flash_dq_oe_b <= 1'b1;
      flash_addr    <= '0;
      flash_dq_o    <= '0;
    end else begin
      flash_ce_b    <= next_ce_b;
      flash_oe_b    <= next_oe_b;
      flash_we_b    <= next_we_b;
      flash_dq_oe_b <= !next_drive;
      flash_addr    <= seq_addr;
      flash_dq_o    <= seq_data;
    end
  end

  // Protection pin is driven low or released to its pull-up.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_wp_oe_b <= 1'b1;
    end else begin
      flash_wp_oe_b <= !wp_enable; // [RULE_02] [RULE_03]
    end
  end

  assign flash_wp_o = 1'b0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      query_mode <= 1'b0;
    end else if (lockout_sync) begin
      query_mode <= 1'b0; // [RULE_05]
    end else if (wr_end && step == last_step) begin
      if (op == fgq_pkg::OP_QUERY_ENTER) begin
        query_mode <= 1'b1; // [RULE_11] [RULE_13]
      end else if (op == fgq_pkg::OP_RESET) begin
        query_mode <= 1'b0; // [RULE_12]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lockout   <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
      rsp_match <= 1'b0;
      rsp_error <= 1'b0;
    end else begin
      lockout   <= lockout_sync;
      rsp_valid <= (state == ST_DONE);
      if (rd_end) begin
        rsp_data  <= dq_sync;
        rsp_match <= (op == fgq_pkg::OP_QUERY_READ) && table_ok; // [RULE_22]
      end else if (state == ST_IDLE && accept) begin
        rsp_data  <= '0;
        rsp_match <= 1'b0;
      end
      if (state == ST_DONE) begin
        rsp_error <= op_err;
      end
    end
  end

  assign cmd_ready = (state == ST_IDLE);

endmodule
`default_nettype wire

// File: fgq_pkg.sv
`default_nettype none
package fgq_pkg;

  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 8;

  typedef enum logic [2:0] {
    OP_READ        = 3'h0,
    OP_WRITE       = 3'h1,
    OP_PROGRAM     = 3'h2,
    OP_QUERY_ENTER = 3'h3,
    OP_RESET       = 3'h4,
    OP_QUERY_READ  = 3'h5
  } fgq_op_e;

  // Command cycles written on the data pins.
  localparam logic [7:0]  CMD_QUERY     = 8'h98;
  localparam logic [7:0]  CMD_RESET     = 8'hf0;
  localparam logic [7:0]  CMD_PROGRAM   = 8'ha0;
  localparam logic [7:0]  UNLOCK1_DATA  = 8'haa;
  localparam logic [7:0]  UNLOCK2_DATA  = 8'h55;
  localparam logic [11:0] UNLOCK1_ADDR  = 12'h555;
  localparam logic [11:0] UNLOCK2_ADDR  = 12'h2aa;
  localparam logic [7:0]  QUERY_ADDR    = 8'h55;

  // Query table offsets (word addresses) and expected contents.
  localparam logic [7:0] QUERY_SIG_Q_OFF             = 8'h10;
  localparam logic [7:0] QUERY_SIG_R_OFF             = 8'h11;
  localparam logic [7:0] QUERY_SIG_Y_OFF             = 8'h12;
  localparam logic [7:0] PRIMARY_CMDSET_LO_OFF       = 8'h13;
  localparam logic [7:0] PRIMARY_CMDSET_HI_OFF       = 8'h14;
  localparam logic [7:0] PRIMARY_EXT_PTR_LO_OFF      = 8'h15;
  localparam logic [7:0] PRIMARY_EXT_PTR_HI_OFF      = 8'h16;
  localparam logic [7:0] ALT_CMDSET_LO_OFF           = 8'h17;
  localparam logic [7:0] ALT_CMDSET_HI_OFF           = 8'h18;
  localparam logic [7:0] ALT_EXT_PTR_LO_OFF          = 8'h19;
  localparam logic [7:0] ALT_EXT_PTR_HI_OFF          = 8'h1a;
  localparam logic [7:0] SUPPLY_MIN_CODE_OFF         = 8'h1b;
  localparam logic [7:0] SUPPLY_MAX_CODE_OFF         = 8'h1c;
  localparam logic [7:0] PROG_VOLT_MIN_CODE_OFF      = 8'h1d;
  localparam logic [7:0] PROG_VOLT_MAX_CODE_OFF      = 8'h1e;
  localparam logic [7:0] RESERVED_QUERY_WORD_OFF     = 8'h1f;
  localparam logic [7:0] TYP_BUFFER_WRITE_EXP_OFF    = 8'h20;
  localparam logic [7:0] TYP_BLOCK_ERASE_EXP_OFF     = 8'h21;
  localparam logic [7:0] TYP_CHIP_ERASE_EXP_OFF      = 8'h22;
  localparam logic [7:0] MAX_SINGLE_PROGRAM_MULT_OFF = 8'h23;
  localparam logic [7:0] MAX_BUFFER_WRITE_MULT_OFF   = 8'h24;
  localparam logic [7:0] MAX_BLOCK_ERASE_MULT_OFF    = 8'h25;
  localparam logic [7:0] MAX_CHIP_ERASE_MULT_OFF     = 8'h26;

  localparam logic [15:0] QUERY_SIG_Q             = 16'h0051;
  localparam logic [15:0] QUERY_SIG_R             = 16'h0052;
  localparam logic [15:0] QUERY_SIG_Y             = 16'h0059;
  localparam logic [15:0] PRIMARY_CMDSET_LO       = 16'h0002;
  localparam logic [15:0] PRIMARY_EXT_PTR_LO      = 16'h0040;
  localparam logic [15:0] SUPPLY_MIN_CODE         = 16'h0027;
  localparam logic [15:0] SUPPLY_MAX_CODE         = 16'h0036;
  localparam logic [15:0] RESERVED_QUERY_WORD     = 16'h0007;
  localparam logic [15:0] TYP_BUFFER_WRITE_EXP    = 16'h0007;
  localparam logic [15:0] TYP_BLOCK_ERASE_EXP     = 16'h000a;
  localparam logic [15:0] MAX_SINGLE_PROGRAM_MULT = 16'h0003;
  localparam logic [15:0] MAX_BUFFER_WRITE_MULT   = 16'h0005;
  localparam logic [15:0] MAX_BLOCK_ERASE_MULT    = 16'h0004;
  localparam logic [15:0] QUERY_ZERO              = 16'h0000;

  // Timing, in ns as specified, and derived clock counts.
  localparam int T_CLK_NS      = 4;
  localparam int T_GLITCH_NS   = 3;
  localparam int T_WE_LOW_NS   = 40;
  localparam int T_WE_HIGH_NS  = 20;
  localparam int T_READ_NS     = 80;
  localparam int T_POWERUP_NS  = 1000;
  localparam int SYNC_CYC      = 2;
  localparam int GLITCH_CYC    = (T_GLITCH_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int WE_LOW_CYC    = (T_WE_LOW_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int WE_HIGH_CYC   = (T_WE_HIGH_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int READ_CYC      = (T_READ_NS + T_CLK_NS - 1) / T_CLK_NS
                                 + SYNC_CYC;
  localparam int POWERUP_CYC   = (T_POWERUP_NS + T_CLK_NS - 1) / T_CLK_NS;

  function automatic logic [15:0] query_expect(input logic [7:0] a);
    case (a)
      QUERY_SIG_Q_OFF:             query_expect = QUERY_SIG_Q;
      QUERY_SIG_R_OFF:             query_expect = QUERY_SIG_R;
      QUERY_SIG_Y_OFF:             query_expect = QUERY_SIG_Y;
      PRIMARY_CMDSET_LO_OFF:       query_expect = PRIMARY_CMDSET_LO;
      PRIMARY_EXT_PTR_LO_OFF:      query_expect = PRIMARY_EXT_PTR_LO;
      SUPPLY_MIN_CODE_OFF:         query_expect = SUPPLY_MIN_CODE;
      SUPPLY_MAX_CODE_OFF:         query_expect = SUPPLY_MAX_CODE;
      RESERVED_QUERY_WORD_OFF:     query_expect = RESERVED_QUERY_WORD;
      TYP_BUFFER_WRITE_EXP_OFF:    query_expect = TYP_BUFFER_WRITE_EXP;
      TYP_BLOCK_ERASE_EXP_OFF:     query_expect = TYP_BLOCK_ERASE_EXP;
      MAX_SINGLE_PROGRAM_MULT_OFF: query_expect = MAX_SINGLE_PROGRAM_MULT;
      MAX_BUFFER_WRITE_MULT_OFF:   query_expect = MAX_BUFFER_WRITE_MULT;
      MAX_BLOCK_ERASE_MULT_OFF:    query_expect = MAX_BLOCK_ERASE_MULT;
      default:                     query_expect = QUERY_ZERO;
    endcase
  endfunction

  function automatic logic query_in_table(input logic [7:0] a);
    query_in_table = (a >= QUERY_SIG_Q_OFF) &&
                     (a <= MAX_CHIP_ERASE_MULT_OFF);
  endfunction

endpackage
`default_nettype wire

// File: fgq_sync.sv
`default_nettype none
module fgq_sync #(
  parameter int W = 1
)(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta;

  // Two-stage synchroniser for pins sampled from outside the clock domain.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule
`default_nettype wire

// File: fgq_host_properties.sv
`default_nettype none
module fgq_host_properties #(
  parameter int ADDR_W = 22
)(
  input wire logic                       clk,
  input wire logic                       rst_b,
  input wire logic                       cmd_valid,
  input wire logic                       cmd_ready,
  input wire logic [2:0]                 cmd_op,
  input wire logic [ADDR_W-1:0]          cmd_addr,
  input wire logic                       wp_enable,
  input wire logic                       rsp_valid,
  input wire logic                       rsp_error,
  input wire logic                       query_mode,
  input wire logic                       lockout,
  input wire logic [fgq_pkg::DATA_W-1:0] flash_dq_o,
  input wire logic                       flash_dq_oe_b,
  input wire logic                       flash_ce_b,
  input wire logic                       flash_oe_b,
  input wire logic                       flash_we_b
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic take = cmd_valid && cmd_ready;
  wire logic bnd  = (&cmd_addr[ADDR_W-1:15]) || !(|cmd_addr[ADDR_W-1:15]);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_WRITE_PINS: assert property (
    !flash_we_b |-> !flash_ce_b && flash_oe_b && !flash_dq_oe_b)
    else $error("write strobe without enable or data");
  AST_WE_WIDTH: assert property (
    $fell(flash_we_b) |-> !flash_we_b [*8])
    else $error("write strobe too short");
  AST_READ_PINS: assert property (
    !flash_oe_b |-> flash_dq_oe_b && flash_we_b)
    else $error("read overlaps a write");
  AST_LOCKOUT_REFUSE: assert property (
    take && lockout && cmd_op inside {[3'h1:3'h4]} |-> ##2 rsp_valid && rsp_error)
    else $error("write accepted under lockout");
  AST_LOCKOUT_QUERY: assert property (
    lockout [*2] |-> !query_mode)
    else $error("query mode kept under lockout");
  AST_QREAD_REFUSE: assert property (
    take && cmd_op == 3'h5 && !query_mode |-> ##2 rsp_valid && rsp_error)
    else $error("query read outside query mode");
  AST_WP_REFUSE: assert property (
    take && cmd_op == 3'h2 && wp_enable && bnd |-> ##2 rsp_valid && rsp_error)
    else $error("boundary program while protected");
  AST_QUERY_ENTER: assert property (
    take && cmd_op == 3'h3 && !lockout |-> ##2 !flash_we_b &&
    flash_dq_o[7:0] == 8'h98 ##16 rsp_valid && query_mode)
    else $error("query entry cycle wrong");
  AST_QUERY_EXIT: assert property (
    take && cmd_op == 3'h4 && !lockout |-> ##18 rsp_valid && !query_mode)
    else $error("reset did not leave query mode");
  AST_QUERY_NO_WRITE: assert property (
    take && query_mode && cmd_op inside {3'h1, 3'h2} |=>
    flash_we_b throughout ##1 (rsp_valid && rsp_error))
    else $error("write issued in query mode");
endmodule
bind fgq_host fgq_host_properties #(.ADDR_W(ADDR_W)) fgq_host_properties_inst (
  .clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .cmd_addr(cmd_addr), .wp_enable(wp_enable),
  .rsp_valid(rsp_valid), .rsp_error(rsp_error), .query_mode(query_mode),
  .lockout(lockout), .flash_dq_o(flash_dq_o), .flash_dq_oe_b(flash_dq_oe_b),
  .flash_ce_b(flash_ce_b), .flash_oe_b(flash_oe_b), .flash_we_b(flash_we_b)
);
`default_nettype wire

// File: fgq_flash_model.sv
`default_nettype none
module fgq_flash_model #(
  parameter int T_ACC_NS = 20,
  parameter int T_PU_NS  = 200,
  parameter bit PROT     = 1'b0
)(
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dq_h,
  input  wire logic        ce_b,
  input  wire logic        oe_b,
  input  wire logic        we_b,
  input  wire logic        wp_pin,
  input  wire logic        byte_mode,
  input  wire logic        lockout,
  output logic      [15:0] dq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [int];
  logic        qry = 1'b0;
  logic        ok = 1'b0;
  int          unl = 0;
  realtime     t_fall = 0;
  wire logic [7:0] qa = byte_mode ? addr[8:1] : addr[7:0];
  wire logic bnd = (&addr[21:15]) || !(|addr[21:15]);
  wire logic rd_en = !ce_b && !oe_b;
  function automatic logic [15:0] tbl(input logic [7:0] a);
    case (a)
      8'h10: tbl = 16'h0051;
      8'h11: tbl = 16'h0052;
      8'h12: tbl = 16'h0059;
      8'h13: tbl = 16'h0002;
      8'h15: tbl = 16'h0040;
      8'h1b: tbl = 16'h0027;
      8'h1c: tbl = 16'h0036;
      8'h1f: tbl = 16'h0007;
      8'h20: tbl = 16'h0007;
      8'h21: tbl = 16'h000a;
      8'h23: tbl = 16'h0003;
      8'h24: tbl = 16'h0005;
      8'h25: tbl = 16'h0004;
      default: tbl = 16'h0000;
    endcase
  endfunction
  // Released data lines show a changed pattern, never the last value.
  initial dq = 16'h0000;
  always @(rd_en) begin
    if (rd_en) begin
      #(T_ACC_NS);
      if (qry) dq = tbl(qa);
      else dq = mem.exists(addr) ? mem[addr] : 16'hffff;
    end else dq = {dq[14:0], ~dq[15]};
  end
  always @(negedge we_b) begin
    t_fall = $realtime;
    ok = !ce_b && oe_b;
  end
  always @(posedge lockout) begin
    qry = 1'b0;
    unl = 0;
  end
  always @(posedge we_b) begin
    if (ok && oe_b && !lockout && $realtime - t_fall >= 3.0 &&
        $realtime > T_PU_NS) begin
      if (!qry && unl == 3) begin
        if (!(bnd && (!wp_pin || PROT))) mem[addr] = dq_h;
        unl = 0;
      end else if (dq_h[7:0] == 8'hf0) begin
        qry = 1'b0;
        unl = 0;
      end else if (dq_h[7:0] == 8'h98 && qa == 8'h55) qry = 1'b1;
      else if (dq_h[7:0] == 8'haa && addr[11:0] == 12'h555) unl = 1;
      else if (unl == 1 && dq_h[7:0] == 8'h55 && addr[11:0] == 12'h2aa) unl = 2;
      else if (unl == 2 && dq_h[7:0] == 8'ha0 && addr[11:0] == 12'h555) unl = 3;
      else unl = 0;
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_b, cmd_valid, byte_mode, wp_enable, flash_lockout;
  logic        cmd_ready, rsp_valid, rsp_match, rsp_error, query_mode, lockout;
  logic        flash_dq_oe_b, flash_ce_b, flash_oe_b, flash_we_b;
  logic        flash_wp_o, flash_wp_oe_b;
  logic [2:0]  cmd_op;
  logic [21:0] cmd_addr, flash_addr, a;
  logic [15:0] cmd_data, rsp_data, flash_dq_o, flash_dq_i, d;
  logic [15:0] bmem [int];
  int          errors = 0;
  int          n_checks = 0;
  logic        qm = 1'b0;
  wire logic   wp_pin = flash_wp_oe_b ? 1'b1 : flash_wp_o;
  fgq_host fgq_host_inst (
    .clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .byte_mode(byte_mode), .wp_enable(wp_enable), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_match(rsp_match), .rsp_error(rsp_error),
    .query_mode(query_mode), .lockout(lockout), .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o), .flash_dq_oe_b(flash_dq_oe_b),
    .flash_dq_i(flash_dq_i), .flash_ce_b(flash_ce_b), .flash_oe_b(flash_oe_b),
    .flash_we_b(flash_we_b), .flash_wp_o(flash_wp_o),
    .flash_wp_oe_b(flash_wp_oe_b), .flash_lockout(flash_lockout)
  );
  fgq_flash_model fgq_flash_model_inst (
    .addr(flash_addr), .dq_h(flash_dq_o), .ce_b(flash_ce_b),
    .oe_b(flash_oe_b), .we_b(flash_we_b), .wp_pin(wp_pin),
    .byte_mode(byte_mode), .lockout(flash_lockout), .dq(flash_dq_i)
  );
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    n_checks++;
    if (g !== x) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmd(input logic [2:0] op, input logic [21:0] ad,
                     input logic [15:0] dd);
    int n;
    logic e, m;
    logic [15:0] xd;
    n = 0;
    e = op > 3'h5 || (op == 3'h5 && !qm) || (op inside {3'h1, 3'h2} && qm) ||
        (op inside {[3'h1:3'h4]} && flash_lockout) ||
        (op == 3'h2 && wp_enable && (&ad[21:15] || !(|ad[21:15])));
    m = !e && op == 3'h5 && ad[7:0] >= 8'h10 && ad[7:0] <= 8'h26;
    xd = 16'h0000;
    if (!e && op == 3'h0) xd = bmem.exists(ad) ? bmem[ad] : 16'hffff;
    if (!e && op == 3'h5) xd = fgq_flash_model_inst.tbl(ad[7:0]);
    if (!e && op == 3'h2) bmem[ad] = dd;
    if (!e && op == 3'h3) qm = 1'b1;
    if (!e && op == 3'h4) qm = 1'b0;
    @(posedge clk) #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = ad;
    cmd_data = dd;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(posedge clk) #1;
      n++;
    end
    @(posedge clk) #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(posedge clk) #1;
      n++;
    end
    chk(16'(n >= 400), 16'h0);
    chk({15'h0, rsp_error}, {15'h0, e});
    chk(rsp_data, xd);
    chk({15'h0, rsp_match}, {15'h0, m});
    chk({15'h0, query_mode}, {15'h0, qm});
  endtask
  initial begin
    #40000;
    chk(16'h1, 16'h0);
    end_sim();
  end
  initial begin
    {cmd_valid, byte_mode, wp_enable, flash_lockout, rst_b} = 5'h0;
    {cmd_op, cmd_addr, cmd_data} = '0;
    void'($urandom(32'h3d0b8445));
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    chk({14'h0, flash_we_b, flash_wp_oe_b}, 16'h0003);
    chk({15'h0, cmd_ready}, 16'h0000);
    cmd(3'h5, 22'h10, 16'h0);
    for (int bm = 0; bm < 2; bm++) begin
      byte_mode = bm[0];
      cmd(3'h3, 22'h55, 16'h0098);
      for (int i = 'h10; i <= 'h27; i++) cmd(3'h5, 22'(i), 16'h0);
      cmd(3'h4, 22'h0, 16'h00f0);
    end
    $display("test query table done");
    for (int i = 0; i < 4; i++) begin
      a = {7'(1 + $urandom % 126), 15'($urandom)};
      d = 16'($urandom);
      cmd(3'h2, a, d);
      cmd(3'h1, a, ~d);
      cmd(3'h0, a, 16'h0);
    end
    $display("test program done");
    wp_enable = 1'b1;
    cmd(3'h2, 22'h000123, d);
    cmd(3'h2, 22'h3f8001, d);
    chk({15'h0, flash_wp_oe_b}, 16'h0000);
    wp_enable = 1'b0;
    cmd(3'h2, 22'h3f8001, d);
    cmd(3'h0, 22'h3f8001, 16'h0);
    $display("test protect done");
    cmd(3'h3, 22'h55, 16'h0098);
    cmd(3'h2, a, 16'h1234);
    cmd(3'h1, a, 16'h1234);
    cmd(3'h4, 22'h0, 16'h00f0);
    cmd(3'h0, a, 16'h0);
    cmd(3'h3, 22'h55, 16'h0098);
    flash_lockout = 1'b1;
    qm = 1'b0;
    repeat (4) @(posedge clk);
    chk({15'h0, query_mode}, 16'h0000);
    chk({15'h0, lockout}, 16'h0001);
    cmd(3'h2, a, 16'h4321);
    cmd(3'h3, 22'h55, 16'h0098);
    cmd(3'h0, a, 16'h0);
    flash_lockout = 1'b0;
    repeat (4) @(posedge clk);
    cmd(3'h2, a, 16'h4321);
    cmd(3'h0, a, 16'h0);
    $display("test lockout done");
    cmd(3'h6, a, 16'h0);
    cmd(3'h7, a, 16'h0);
    $display("test refused ops done");
    end_sim();
  end
endmodule
`default_nettype wire
